// ### shared/bol_pkg.sv
// Package: constants and types for the bit-operation and data-load execution block
`default_nettype none
package bol_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ARG    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RSEL   = 8'h0c;
  localparam logic [7:0] OFF_RDATA  = 8'h10;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_DST_LSB = 8;
  localparam int CMD_BIT_LSB = 16;
  localparam int CMD_PTR_LSB = 20;
  localparam int STAT_BUSY   = 8;
  localparam int DISP_W      = 6;

  // ----------------------------------------------------------------
  // Status flag positions and reset values
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] ARG_RST   = 16'h0000;
  localparam logic [4:0]  PTR_BASE  = 5'h1a;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    op_nop, op_rotr, op_ashr, op_tstore, op_tfetch, op_fset, op_fclr,
    op_ind, op_ind_inc, op_ind_dec, op_disp, op_dir
  } bol_op_type;

  typedef enum logic [0:0] {st_idle, st_load} bol_st_type;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
  } bol_mem_req_type;

endpackage : bol_pkg
`default_nettype wire

// ### src/bol_exec.sv
// Module: bit-operation and data-load execution unit with AXI4-Lite control
//
// How it works
// - Rotate right through carry, one place; flags Z,C,N,V updated in one cycle
// - Arithmetic shift right keeps bit 7; flags Z,C,N,V updated in one cycle
// - Bit store copies selected register bit into T only, one cycle
// - Bit load writes T into selected register bit, flags unchanged, one cycle
// - Each status flag can be set alone, others untouched, one cycle
// - Each status flag can be cleared alone; generic form picks bit by operand
// - Sign flag settable directly by the generic flag set with bit 4 selected, one cycle
// - Overflow clear zeroes only V in one cycle
// - Indirect load via X, Y or Z, optional post-increment, two cycles
// - Pre-decrement load lowers pointer first, reads new address, two cycles
// - Displacement load reads X, Y or Z plus offset, pointer unchanged, two cycles
// - Direct load reads byte at immediate address, two cycles, no flags
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module bol_exec
  import bol_pkg::*;
(
  input  wire logic                      aclk,           // Core clock
  input  wire logic                      aresetn,        // Sync reset, active low
  input  wire logic [7:0]                awaddr,         // Write address
  input  wire logic                      awvalid,        // Write address valid
  output logic                           awready,        // Write address ready
  input  wire logic [31:0]               wdata,          // Write data
  input  wire logic [3:0]                wstrb,          // Write strobes
  input  wire logic                      wvalid,         // Write data valid
  output logic                           wready,         // Write data ready
  output logic [1:0]                     bresp,          // Write response
  output logic                           bvalid,         // Write response valid
  input  wire logic                      bready,         // Write response ready
  input  wire logic [7:0]                araddr,         // Read address
  input  wire logic                      arvalid,        // Read address valid
  output logic                           arready,        // Read address ready
  output logic [31:0]                    rdata,          // Read data
  output logic [1:0]                     rresp,          // Read response
  output logic                           rvalid,         // Read data valid
  input  wire logic                      rready,         // Read data ready
  output bol_pkg::bol_mem_req_type       mem_req,        // Data memory request
  input  wire logic [7:0]                mem_rdata,      // Data byte, sampled in the same cycle as rd
  output logic [7:0]                     status_register // Live status flags
);
  import bol_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0][7:0] rf;
    logic [7:0]       flags;
    bol_st_type       st;
    logic [4:0]       pend_dst;
    logic [1:0]       pend_ptr;
    logic             pend_post;
    bol_mem_req_type  mem;
    logic [15:0]      arg;
    logic [4:0]       rf_sel;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } bol_state_type;

  bol_state_type state_reg;
  bol_state_type state_next;

  logic        aw_take;
  logic        ar_take;
  logic        h_fire;
  bol_op_type  h_op;
  logic [4:0]  h_d;
  logic [2:0]  h_b;
  logic [1:0]  h_p;
  logic [7:0]  h_dv;
  logic [15:0] h_pv;
  logic [15:0] h_ldpv;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    logic [1:0] s;
    s = (sel == 2'h3) ? 2'h2 : sel;
    ptr_lo = PTR_BASE + {2'h0, s, 1'b0};
  endfunction : ptr_lo

  function automatic logic [15:0] ptr_val(input logic [31:0][7:0] rf, input logic [1:0] sel);
    ptr_val = {rf[ptr_lo(sel) + 5'h01], rf[ptr_lo(sel)]};
  endfunction : ptr_val

  function automatic logic [7:0] shift_flags(input logic [7:0] sr, input logic [7:0] res,
                                             input logic cout);
    logic [7:0] f;
    f        = sr;
    f[FLG_C] = cout;
    f[FLG_Z] = (res == 8'h00);
    f[FLG_N] = res[7];
    f[FLG_V] = res[7] ^ cout;
    f[FLG_S] = res[7] ^ f[FLG_V];
    shift_flags = f;
  endfunction : shift_flags

  assign aw_take = awvalid && wvalid && !state_reg.bvalid;
  assign ar_take = arvalid && !state_reg.rvalid;
  assign h_fire  = aw_take && (awaddr == OFF_CMD) && (state_reg.st == st_idle);
  assign h_op    = bol_op_type'(wdata[CMD_OP_LSB +: 4]);
  assign h_d     = wdata[CMD_DST_LSB +: 5];
  assign h_b     = wdata[CMD_BIT_LSB +: 3];
  assign h_p     = wdata[CMD_PTR_LSB +: 2];
  assign h_dv    = state_reg.rf[h_d];
  assign h_pv    = ptr_val(state_reg.rf, h_p);
  assign h_ldpv  = ptr_val(state_reg.rf, state_reg.pend_ptr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0]  res;
    logic [15:0] pdec;
    logic [15:0] pinc;
    res  = 8'h00;
    pdec = h_pv - 16'h0001;
    pinc = h_ldpv + 16'h0001;
    state_next        = state_reg;
    state_next.mem.rd = 1'b0;
    if (state_reg.bvalid && bready)
    begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && rready)
    begin
      state_next.rvalid = 1'b0;
    end
    // Second cycle of a load: capture byte, then optional post-increment
    if (state_reg.st == st_load)
    begin
      state_next.rf[state_reg.pend_dst] = mem_rdata;
      if (state_reg.pend_post)
      begin
        state_next.rf[ptr_lo(state_reg.pend_ptr)]         = pinc[7:0];
        state_next.rf[ptr_lo(state_reg.pend_ptr) + 5'h01] = pinc[15:8];
      end
      state_next.st = st_idle;
    end
    if (aw_take)
    begin
      state_next.bvalid = 1'b1;
      state_next.bresp  = RESP_OKAY;
      unique case (awaddr)
        OFF_CMD:
        begin
          if (state_reg.st != st_idle)
          begin
            state_next.bresp = RESP_SLVERR;
          end
          else
          begin
            state_next.pend_dst  = h_d;
            state_next.pend_ptr  = h_p;
            state_next.pend_post = 1'b0;
            case (h_op)
              op_rotr:
              begin
                res = {state_reg.flags[FLG_C], h_dv[7:1]};
                state_next.rf[h_d] = res;
                state_next.flags   = shift_flags(state_reg.flags, res, h_dv[0]);
              end
              op_ashr:
              begin
                res = {h_dv[7], h_dv[7:1]};
                state_next.rf[h_d] = res;
                state_next.flags   = shift_flags(state_reg.flags, res, h_dv[0]);
              end
              op_tstore: state_next.flags[FLG_T] = h_dv[h_b];
              op_tfetch: state_next.rf[h_d][h_b] = state_reg.flags[FLG_T];
              op_fset:   state_next.flags[h_b] = 1'b1;
              op_fclr:   state_next.flags[h_b] = 1'b0;
              op_ind, op_ind_inc:
              begin
                state_next.mem       = '{addr: h_pv, rd: 1'b1};
                state_next.pend_post = (h_op == op_ind_inc);
                state_next.st        = st_load;
              end
              op_ind_dec:
              begin
                state_next.rf[ptr_lo(h_p)]         = pdec[7:0];
                state_next.rf[ptr_lo(h_p) + 5'h01] = pdec[15:8];
                state_next.mem = '{addr: pdec, rd: 1'b1};
                state_next.st  = st_load;
              end
              op_disp:
              begin
                state_next.mem = '{addr: h_pv + {10'h000, state_reg.arg[DISP_W-1:0]},
                                   rd: 1'b1};
                state_next.st  = st_load;
              end
              op_dir:
              begin
                state_next.mem = '{addr: state_reg.arg, rd: 1'b1};
                state_next.st  = st_load;
              end
              default: state_next.bresp = RESP_OKAY;
            endcase
          end
        end
        OFF_ARG:
        begin
          if (wstrb[0])
          begin
            state_next.arg[7:0] = wdata[7:0];
          end
          if (wstrb[1])
          begin
            state_next.arg[15:8] = wdata[15:8];
          end
        end
        OFF_STATUS:
        begin
          if (wstrb[0])
          begin
            state_next.flags = wdata[7:0];
          end
        end
        OFF_RSEL:
        begin
          if (wstrb[0])
          begin
            state_next.rf_sel = wdata[4:0];
          end
        end
        OFF_RDATA:
        begin
          if (wstrb[0])
          begin
            state_next.rf[state_reg.rf_sel] = wdata[7:0];
          end
        end
        default: state_next.bresp = RESP_SLVERR;
      endcase
    end
    if (ar_take)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = RESP_OKAY;
      state_next.rdata  = 32'h0000_0000;
      unique case (araddr)
        OFF_CMD:    state_next.rdata = 32'h0000_0000;
        OFF_ARG:    state_next.rdata = {16'h0000, state_reg.arg};
        OFF_STATUS: state_next.rdata = {23'h00_0000, state_reg.st == st_load,
                                        state_reg.flags};
        OFF_RSEL:   state_next.rdata = {27'h000_0000, state_reg.rf_sel};
        OFF_RDATA:  state_next.rdata = {24'h00_0000, state_reg.rf[state_reg.rf_sel]};
        default:    state_next.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg       <= '0;
      state_reg.flags <= FLAGS_RST;
      state_reg.arg   <= ARG_RST;
      state_reg.st    <= st_idle;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready         = aw_take;
  assign wready          = aw_take;
  assign bvalid          = state_reg.bvalid;
  assign bresp           = state_reg.bresp;
  assign arready         = !state_reg.rvalid;
  assign rvalid          = state_reg.rvalid;
  assign rdata           = state_reg.rdata;
  assign rresp           = state_reg.rresp;
  assign mem_req         = state_reg.mem;
  assign status_register = state_reg.flags;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rotr;
    h_fire && h_op == op_rotr |=> state_reg.rf[$past(h_d)] == {$past(status_register[FLG_C]),
      $past(h_dv[7:1])} && status_register[FLG_C] == $past(h_dv[0])
      && status_register[FLG_S] == (status_register[FLG_N] ^ status_register[FLG_V]);
  endproperty
  a_rotr: assert property (p_rotr) else $error("rotate right result wrong");
  property p_ashr;
    h_fire && h_op == op_ashr |=> state_reg.rf[$past(h_d)][7:6] == {2{$past(h_dv[7])}}
      && status_register[FLG_V] == (status_register[FLG_N] ^ status_register[FLG_C]);
  endproperty
  a_ashr: assert property (p_ashr) else $error("arith shift result wrong");
  property p_tstore;
    h_fire && h_op == op_tstore |=> status_register[FLG_T] == $past(h_dv[h_b])
      && (status_register & 8'hbf) == ($past(status_register) & 8'hbf);
  endproperty
  a_tstore: assert property (p_tstore) else $error("bit store wrong");
  property p_tfetch;
    h_fire && h_op == op_tfetch |=> $stable(status_register)
      && state_reg.rf[$past(h_d)][$past(h_b)] == status_register[FLG_T];
  endproperty
  a_tfetch: assert property (p_tfetch) else $error("bit load wrong");
  property p_fset;
    h_fire && h_op == op_fset |=> status_register == ($past(status_register)
      | (8'h01 << $past(h_b)));
  endproperty
  a_fset: assert property (p_fset) else $error("flag set wrong");
  property p_fclr;
    h_fire && h_op == op_fclr |=> status_register == ($past(status_register)
      & ~(8'h01 << $past(h_b)));
  endproperty
  a_fclr: assert property (p_fclr) else $error("flag clear wrong");
  property p_sign_set;
    h_fire && h_op == op_fset && h_b == 3'(FLG_S) |=> status_register[FLG_S];
  endproperty
  a_sign_set: assert property (p_sign_set) else $error("sign set failed");
  property p_ovf_clear;
    h_fire && h_op == op_fclr && h_b == 3'(FLG_V) |=> !status_register[FLG_V]
      && status_register[FLG_C] == $past(status_register[FLG_C]);
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow clear wrong");
  // Post-increment into its own pointer lets the pointer win, so skip that case
  sequence s_ind_issue;
    h_fire && (h_op == op_ind || (h_op == op_ind_inc && h_d[4:1] < 4'hd));
  endsequence
  sequence s_ind_done;
    mem_req.rd ##1 (state_reg.st == st_idle && state_reg.rf[state_reg.pend_dst]
      == $past(mem_rdata));
  endsequence
  property p_ind;
    s_ind_issue |=> mem_req.addr == $past(h_pv) ##0 s_ind_done;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect load wrong");
  property p_ind_inc;
    h_fire && h_op == op_ind_inc && h_d[4:1] != 4'hd && h_d[4:3] != 2'h3
      |=> ##1 h_ldpv == $past(h_ldpv) + 16'h0001;
  endproperty
  a_ind_inc: assert property (p_ind_inc) else $error("post increment wrong");
  property p_ind_dec;
    h_fire && h_op == op_ind_dec |=> mem_req.rd && mem_req.addr == $past(h_pv) - 16'h0001
      && h_ldpv == mem_req.addr;
  endproperty
  a_ind_dec: assert property (p_ind_dec) else $error("pre decrement wrong");
  property p_disp;
    h_fire && h_op == op_disp && h_d[4:3] != 2'h3 |=> mem_req.addr == $past(h_pv)
      + {10'h000, state_reg.arg[DISP_W-1:0]} ##1 h_ldpv == $past(h_ldpv);
  endproperty
  a_disp: assert property (p_disp) else $error("displacement load wrong");
  property p_dir;
    h_fire && h_op == op_dir |=> mem_req.rd && mem_req.addr == state_reg.arg
      ##1 $stable(status_register) && state_reg.st == st_idle;
  endproperty
  a_dir: assert property (p_dir) else $error("direct load wrong");

endmodule : bol_exec
`default_nettype wire

// ### tb/bol_exec_test.sv
// Self-checking testbench for the execution block
`default_nettype none
module bol_exec_test
  import bol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, mem_rdata, status_register;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  bol_mem_req_type mem_req;
  int n_reads, bad_count = 0, n_compared = 0, cycles = 0;

  bol_exec u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .status_register(status_register));

  bol_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .n_reads(n_reads));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (!(awready && wready)) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write resp", RESP_OKAY, r);
  endtask : wr
  task automatic set_reg(input logic [4:0] i, input logic [7:0] v);
    wr(OFF_RSEL, {27'h0, i});
    wr(OFF_RDATA, {24'h0, v});
  endtask : set_reg
  task automatic get_reg(input logic [4:0] i, output logic [7:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFF_RSEL, {27'h0, i});
    axi_read(OFF_RDATA, d, r);
    v = d[7:0];
  endtask : get_reg

  function automatic logic [31:0] cmd(input logic [3:0] op, input logic [4:0] dst,
                                      input logic [2:0] b, input logic [1:0] p);
    return {10'h0, p, 1'b0, b, 3'h0, dst, 4'h0, op};
  endfunction : cmd

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
  endfunction : mem_byte

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    logic [31:0] d;
    logic [1:0]  r;
    check("status port", 32'h0, {24'h0, status_register});
    axi_read(OFF_STATUS, d, r);
    check("status reg", 32'h0, d);
    axi_read(8'h14, d, r);
    check("unmapped read resp", RESP_SLVERR, r);
    check("unmapped read data", 32'h0, d);
    axi_write(8'h18, 32'hffff_ffff, r);
    check("unmapped write resp", RESP_SLVERR, r);
    $display("test reset done");
  endtask : test_reset

  task automatic test_shift();
    logic [3:0]  ops [4] = '{op_rotr, op_rotr, op_ashr, op_ashr};
    logic [7:0]  vals [4] = '{8'h81, 8'h01, 8'h80, 8'h01};
    logic [7:0]  sts [4] = '{8'he1, 8'h00, 8'ha0, 8'h41};
    logic [7:0]  res, got;
    logic        n, v;
    for (int k = 0; k < 4; k++)
    begin
      res = (ops[k] == op_rotr) ? {sts[k][0], vals[k][7:1]} : {vals[k][7], vals[k][7:1]};
      n = res[7];
      v = n ^ vals[k][0];
      set_reg(5'd5, vals[k]);
      wr(OFF_STATUS, {24'h0, sts[k]});
      wr(OFF_CMD, cmd(ops[k], 5'd5, 3'd0, 2'd0));
      check("shift flags", {sts[k][7:5], n ^ v, v, n, res == 8'h00, vals[k][0]},
            status_register);
      get_reg(5'd5, got);
      check("shift result", res, got);
    end
    $display("test shift done");
  endtask : test_shift

  task automatic test_bits();
    logic [7:0] got;
    set_reg(5'd3, 8'h20);
    wr(OFF_STATUS, 32'h0);
    wr(OFF_CMD, cmd(op_tstore, 5'd3, 3'd5, 2'd0));
    check("store one", 32'h40, status_register);
    wr(OFF_STATUS, 32'hff);
    wr(OFF_CMD, cmd(op_tstore, 5'd3, 3'd4, 2'd0));
    check("store zero", 32'hbf, status_register);
    set_reg(5'd7, 8'hff);
    wr(OFF_CMD, cmd(op_tfetch, 5'd7, 3'd0, 2'd0));
    check("load flags", 32'hbf, status_register);
    wr(OFF_CMD, cmd(op_nop, 5'd7, 3'd0, 2'd0));
    wr(OFF_CMD, cmd(4'hc, 5'd7, 3'd0, 2'd0));
    check("idle op flags", 32'hbf, status_register);
    get_reg(5'd7, got);
    check("load bit", 32'hfe, got);
    for (int b = 0; b < 8; b++)
    begin
      wr(OFF_STATUS, 32'h0);
      wr(OFF_CMD, cmd(op_fset, 5'd0, b[2:0], 2'd0));
      check("flag set", 32'h1 << b, status_register);
      wr(OFF_STATUS, 32'hff);
      wr(OFF_CMD, cmd(op_fclr, 5'd0, b[2:0], 2'd0));
      check("flag clear", ~(32'h1 << b) & 32'hff, status_register);
    end
    $display("test bits done");
  endtask : test_bits

  task automatic do_load(input logic [3:0] op, input logic [1:0] p, input logic [15:0] pv,
                         input logic [15:0] arg, input logic [15:0] ea, input logic [15:0] pe);
    logic [4:0] base;
    logic [7:0] lo, hi, d;
    int         nr;
    base = PTR_BASE + {((p == 2'd3) ? 2'd2 : p), 1'b0};
    set_reg(base, pv[7:0]);
    set_reg(base + 5'd1, pv[15:8]);
    wr(OFF_ARG, {16'h0, arg});
    wr(OFF_STATUS, 32'h96);
    nr = n_reads;
    wr(OFF_CMD, cmd(op, 5'd1, 3'd0, p));
    get_reg(5'd1, d);
    check("load data", mem_byte(ea), d);
    get_reg(base, lo);
    get_reg(base + 5'd1, hi);
    check("pointer", pe, {hi, lo});
    check("load flags", 32'h96, status_register);
    check("read count", nr + 1, n_reads);
  endtask : do_load

  task automatic test_loads();
    do_load(op_ind, 2'd0, 16'h12ff, 16'h0, 16'h12ff, 16'h12ff);
    do_load(op_ind_inc, 2'd0, 16'h12ff, 16'h0, 16'h12ff, 16'h1300);
    do_load(op_ind_inc, 2'd1, 16'hffff, 16'h0, 16'hffff, 16'h0000);
    do_load(op_ind_dec, 2'd1, 16'h2000, 16'h0, 16'h1fff, 16'h1fff);
    do_load(op_ind_dec, 2'd2, 16'h0100, 16'h0, 16'h00ff, 16'h00ff);
    do_load(op_disp, 2'd1, 16'h00f0, 16'h003f, 16'h012f, 16'h00f0);
    do_load(op_disp, 2'd2, 16'h1234, 16'h0000, 16'h1234, 16'h1234);
    do_load(op_dir, 2'd0, 16'h0000, 16'hbeef, 16'hbeef, 16'h0000);
    do_load(op_ind, 2'd3, 16'h4567, 16'h0, 16'h4567, 16'h4567);
    $display("test loads done");
  endtask : test_loads

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_shift();
    test_bits();
    test_loads();
    complete_run();
  end
endmodule : bol_exec_test
`default_nettype wire

// ### tb/bol_mem_model.sv
// Data memory partner model for the execution block
`default_nettype none
module bol_mem_model
  import bol_pkg::*;
(
  input  wire logic                     aclk,      // Core clock
  input  wire logic                     aresetn,   // Sync reset, active low
  input  wire bol_pkg::bol_mem_req_type mem_req,   // Request from block
  output logic [7:0]                    mem_rdata, // Byte returned
  output int                            n_reads    // Read pulses seen
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] junk_reg;

  // Contents derived from address, no storage needed
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
  endfunction : byte_at

  // Changing junk outside a read, so a late sample never matches by luck
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      junk_reg <= 8'h00;
      n_reads  <= 0;
    end
    else
    begin
      junk_reg <= junk_reg + 8'h5b;
      if (mem_req.rd)
        n_reads <= n_reads + 1;
    end
  end

  assign mem_rdata = mem_req.rd ? byte_at(mem_req.addr) : junk_reg;
endmodule : bol_mem_model
`default_nettype wire
